// file: inc/skl_pkg.sv
// Constants for the security key lockout block
package skl_pkg;
   // Register offsets (byte addresses, one word each)
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_CMD       = 8'h04;
   localparam logic [7:0] ADDR_KEY       = 8'h08;
   localparam logic [7:0] ADDR_STATUS    = 8'h0C;
   localparam logic [7:0] ADDR_RESULT    = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;
   localparam logic [7:0] ADDR_PERS_SET  = 8'h1C;
   localparam logic [7:0] ADDR_PING_SIZE = 8'h20;
   localparam logic [7:0] ADDR_PING_TMO  = 8'h24;
   localparam logic [7:0] ADDR_UPTIME    = 8'h28;
   localparam logic [7:0] ADDR_PING_CNT  = 8'h2C;
   localparam logic [7:0] ADDR_CRED      = 8'h30;
   localparam logic [7:0] ADDR_NET       = 8'h34;

   // Key defaults (arbitrary values)
   localparam logic [31:0] PERS_KEY_RST   = 32'h0000_1234;
   localparam logic [31:0] UNBLK_KEY_RST  = 32'h1234_5678;
   localparam logic [31:0] PROV_KEY_RST   = 32'h0000_4321;
   localparam logic [31:0] MASTER_KEY     = 32'h8765_4321;

   // Failure limits
   localparam logic [3:0] PERS_FAIL_MAX  = 4'h3;
   localparam logic [3:0] UNBLK_FAIL_MAX = 4'hA;
   localparam logic [3:0] PROV_FAIL_MAX  = 4'h3;

   // Echo test defaults
   localparam logic [15:0] PING_DATA_RST  = 16'h003C;
   localparam logic [15:0] PING_HDR       = 16'h0008;
   localparam logic [15:0] PING_TMO_RST   = 16'h000A;

   // Timing
   localparam int CLK_HZ        = 10_000_000;
   localparam int BLOCK_DELAY_S = 30;
   localparam int BLOCK_DELAY_CYC = BLOCK_DELAY_S * CLK_HZ;
   localparam int SEC_CYC       = CLK_HZ;

   // Commands written to the command register
   localparam logic [3:0] CMD_PERS_ENTRY = 4'h1;
   localparam logic [3:0] CMD_UNBLOCK    = 4'h2;
   localparam logic [3:0] CMD_CLEAR      = 4'h3;
   localparam logic [3:0] CMD_PERS_SET   = 4'h4;
   localparam logic [3:0] CMD_PROV_ENTRY = 4'h5;
   localparam logic [3:0] CMD_REGISTER   = 4'h6;
   localparam logic [3:0] CMD_DIAL       = 4'h7;
   localparam logic [3:0] CMD_PROT_WRITE = 4'h8;
   localparam logic [3:0] CMD_PING_START = 4'h9;
   localparam logic [3:0] CMD_PING_STOP  = 4'hA;
   localparam logic [3:0] CMD_SOFT_RESET = 4'hB;

   // Result codes
   localparam logic [2:0] RES_OK      = 3'h1;
   localparam logic [2:0] RES_ERROR   = 3'h2;
   localparam logic [2:0] RES_BLOCKED = 3'h3;
   localparam logic [2:0] RES_BUSY    = 3'h4;

   // Control and status bit positions
   localparam int CTRL_PERS_REQ  = 0;
   localparam int IRQ_DONE       = 0;
   localparam int IRQ_BLOCK      = 1;
   localparam int IRQ_REPLY      = 2;
   localparam int IRQ_PING_END   = 3;
   localparam int NET_ENC        = 0;
endpackage

// file: rtl/skl_core.sv
// Key lockout, command gate and echo-test bookkeeping for the modem
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Register and dial refused while personal key required and not entered.
// [RULE2] Three wrong personal key entries in a row block it.
// [RULE3] Personal key not required after reset; software may enable requirement.
// [RULE4] Correct unblock key temporarily re-enables blocked personal key for set.
// [RULE5] Ten wrong unblock key entries in a row block the unblock key.
// [RULE6] Clear command removes personal and unblock key blocks for good.
// [RULE7] Protected changes refused unless provider key entered.
// [RULE8] Provider key requirement always enforced, no disable.
// [RULE9] Three wrong provider key entries in a row block it.
// [RULE10] Blocked provider key entry waits thirty seconds then answers blocked.
// [RULE11] Master key temporarily unblocks provider key; clear makes it permanent.
// [RULE12] Master key never blocks.
// [RULE13] A correct entry zeroes that key's failure counter.
// [RULE14] Echo test runs until stop, then totals are reported.
// [RULE15] Echo defaults 60 data plus 8 header bytes, 10 s time-out, adjustable.
// [RULE16] Reply reports carry seconds since last reset.
// [RULE17] Encryption follows the network's registration decision.
// [RULE18] Credentials start at zero, updated from the network on registration.
module skl_core
   import skl_pkg::*;
#(
   parameter int DELAY_CYC = BLOCK_DELAY_CYC,
   parameter int SEC_CYCLES = SEC_CYC
)(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // Register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata,
   // Network side events
   input  wire logic        net_reg_done,
   input  wire logic        net_enc_on,
   input  wire logic [31:0] net_cred,
   input  wire logic        echo_reply,
   // Outputs
   output logic             encrypt_en,
   output logic             reg_req,
   output logic             dial_req,
   output logic             ping_active,
   output logic             irq
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] rdata;
      logic [31:0] key;
      logic [31:0] pers_key;
      logic        pers_req;
      logic        pers_ok;
      logic        pers_blk;
      logic        pers_tmp;
      logic [3:0]  pers_fail;
      logic        unblk_blk;
      logic [3:0]  unblk_fail;
      logic        prov_ok;
      logic        prov_blk;
      logic [3:0]  prov_fail;
      logic [31:0] delay;
      logic        delaying;
      logic [2:0]  result;
      logic [3:0]  irq_stat;
      logic [3:0]  irq_mask;
      logic [15:0] ping_size;
      logic [15:0] ping_tmo;
      logic [31:0] uptime;
      logic [31:0] sec_cnt;
      logic        ping_on;
      logic [15:0] tx_cnt;
      logic [15:0] rx_cnt;
      logic [31:0] cred;
      logic        enc;
      logic        reg_req;
      logic        dial_req;
      logic        irq;
   } skl_state_s;

   skl_state_s st, next_st;

   // Synchronisers for the network event inputs (registration done and echo reply)
   logic [1:0] done_sync, reply_sync;
   logic       done_last, reply_last;
   logic       done_ev, reply_ev;

   // Two-stage capture of asynchronous event lines
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         done_sync  <= 2'h0;
         reply_sync <= 2'h0;
         done_last  <= 1'b0;
         reply_last <= 1'b0;
      end else begin
         done_sync  <= {done_sync[0], net_reg_done};
         reply_sync <= {reply_sync[0], echo_reply};
         done_last  <= done_sync[1];
         reply_last <= reply_sync[1];
      end
   end
   assign done_ev  = done_sync[1] & ~done_last;
   assign reply_ev = reply_sync[1] & ~reply_last;

   // Failure count step with saturation at the block limit
   function automatic logic [3:0] fail_step(input logic [3:0] c, input logic [3:0] lim);
      fail_step = (c < lim) ? c + 4'h1 : c;
   endfunction

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   always_comb begin
      logic [3:0] cmd;
      logic [3:0] ev;
      cmd = wdata[3:0];
      ev  = 4'h0;
      next_st = st;
      next_st.reg_req  = 1'b0;
      next_st.dial_req = 1'b0;
      next_st.rdata    = 32'h0000_0000;

      // Seconds since reset
      if (st.sec_cnt == 32'(SEC_CYCLES - 1)) begin
         next_st.sec_cnt = 32'h0000_0000;
         next_st.uptime  = st.uptime + 32'h0000_0001;     // [RULE16]
      end else begin
         next_st.sec_cnt = st.sec_cnt + 32'h0000_0001;
      end

      // Blocked provider entry delay
      if (st.delaying) begin
         if (st.delay == 32'h0000_0000) begin
            next_st.delaying = 1'b0;
            next_st.result   = RES_BLOCKED;               // [RULE10]
            ev[IRQ_DONE]     = 1'b1;
         end else begin
            next_st.delay = st.delay - 32'h0000_0001;
         end
      end

      // Network registration result
      if (done_ev) begin
         next_st.enc  = net_enc_on;                       // [RULE17]
         next_st.cred = net_cred;                         // [RULE18]
      end
      if (reply_ev && st.ping_on) begin
         next_st.rx_cnt    = st.rx_cnt + 16'h0001;
         next_st.tx_cnt    = st.tx_cnt + 16'h0001;        // [RULE14]
         ev[IRQ_REPLY]     = 1'b1;
      end

      // Register writes
      if (wr) begin
         unique case (addr)
            ADDR_CTRL:      next_st.pers_req = wdata[CTRL_PERS_REQ]; // [RULE3]
            ADDR_KEY:       next_st.key = wdata;
            ADDR_IRQ_STAT:  next_st.irq_stat = st.irq_stat & ~wdata[3:0];
            ADDR_IRQ_MASK:  next_st.irq_mask = wdata[3:0];
            ADDR_PING_SIZE: if (st.prov_ok) next_st.ping_size = wdata[15:0]; // [RULE15]
            ADDR_PING_TMO:  if (st.prov_ok) next_st.ping_tmo = wdata[15:0];  // [RULE7]
            ADDR_CMD: begin
               ev[IRQ_DONE] = 1'b1;
               next_st.result = RES_OK;
               if (st.delaying) begin
                  // A pending delay refuses the command: blocked once the delay has run out, busy before
                  next_st.result = (st.delay == 32'h0000_0000) ? RES_BLOCKED : RES_BUSY;
               end else begin
                  unique case (cmd)
                     CMD_PERS_ENTRY: begin
                        if (st.pers_blk) begin
                           next_st.result = RES_BLOCKED;
                        end else if (st.key == st.pers_key) begin
                           next_st.pers_ok   = 1'b1;
                           next_st.pers_fail = 4'h0;                    // [RULE13]
                        end else begin
                           next_st.result    = RES_ERROR;
                           next_st.pers_fail = fail_step(st.pers_fail, PERS_FAIL_MAX);
                           if (st.pers_fail == PERS_FAIL_MAX - 4'h1) begin
                              next_st.pers_blk = 1'b1;                  // [RULE2]
                              next_st.pers_ok  = 1'b0;
                              ev[IRQ_BLOCK]    = 1'b1;
                           end
                        end
                     end
                     CMD_UNBLOCK: begin
                        if (st.unblk_blk) begin
                           next_st.result = RES_BLOCKED;
                        end else if (st.key == UNBLK_KEY_RST) begin
                           next_st.pers_tmp   = 1'b1;                   // [RULE4]
                           next_st.unblk_fail = 4'h0;                   // [RULE13]
                        end else begin
                           next_st.result     = RES_ERROR;
                           next_st.unblk_fail = fail_step(st.unblk_fail, UNBLK_FAIL_MAX);
                           if (st.unblk_fail == UNBLK_FAIL_MAX - 4'h1) begin
                              next_st.unblk_blk = 1'b1;                 // [RULE5]
                              ev[IRQ_BLOCK]     = 1'b1;
                           end
                        end
                     end
                     CMD_PERS_SET: begin
                        if (!st.pers_blk || st.pers_tmp) begin
                           next_st.pers_key  = st.key;                  // [RULE4]
                           next_st.pers_blk  = 1'b0;
                           next_st.pers_fail = 4'h0;
                           next_st.pers_tmp  = 1'b0;
                        end else begin
                           next_st.result = RES_BLOCKED;
                        end
                     end
                     CMD_CLEAR: begin
                        if (st.prov_ok) begin
                           next_st.pers_blk   = 1'b0;                   // [RULE6]
                           next_st.unblk_blk  = 1'b0;
                           next_st.pers_fail  = 4'h0;
                           next_st.unblk_fail = 4'h0;
                           next_st.prov_blk   = 1'b0;                   // [RULE11]
                           next_st.prov_fail  = 4'h0;
                        end else begin
                           next_st.result = RES_ERROR;                  // [RULE7]
                        end
                     end
                     CMD_PROV_ENTRY: begin
                        if (st.key == MASTER_KEY) begin
                           next_st.prov_ok   = 1'b1;                    // [RULE11]
                           next_st.prov_fail = 4'h0;                    // [RULE12]
                        end else if (st.prov_blk) begin
                           next_st.delaying = 1'b1;                     // [RULE10]
                           next_st.delay    = 32'(DELAY_CYC - 1);
                           ev[IRQ_DONE]     = 1'b0;
                           next_st.result   = RES_BUSY;
                        end else if (st.key == PROV_KEY_RST) begin
                           next_st.prov_ok   = 1'b1;
                           next_st.prov_fail = 4'h0;                    // [RULE13]
                        end else begin
                           next_st.result    = RES_ERROR;
                           next_st.prov_fail = fail_step(st.prov_fail, PROV_FAIL_MAX);
                           if (st.prov_fail == PROV_FAIL_MAX - 4'h1) begin
                              next_st.prov_blk = 1'b1;                  // [RULE9]
                              next_st.prov_ok  = 1'b0;
                              ev[IRQ_BLOCK]    = 1'b1;
                           end
                        end
                     end
                     CMD_REGISTER, CMD_DIAL: begin
                        if (st.pers_req && !st.pers_ok) begin
                           next_st.result = RES_ERROR;                  // [RULE1]
                        end else if (cmd == CMD_REGISTER) begin
                           next_st.reg_req = 1'b1;
                        end else begin
                           next_st.dial_req = 1'b1;
                        end
                     end
                     CMD_PROT_WRITE: begin
                        if (!st.prov_ok) next_st.result = RES_ERROR;    // [RULE8]
                        else next_st.cred = 32'h0000_0000;              // [RULE18]
                     end
                     CMD_PING_START: begin
                        next_st.ping_on = 1'b1;
                        next_st.tx_cnt  = 16'h0000;
                        next_st.rx_cnt  = 16'h0000;
                     end
                     CMD_PING_STOP: begin
                        next_st.ping_on = 1'b0;                         // [RULE14]
                        ev[IRQ_PING_END] = st.ping_on;
                     end
                     CMD_SOFT_RESET: begin
                        next_st.uptime  = 32'h0000_0000;                // [RULE16]
                        next_st.sec_cnt = 32'h0000_0000;
                     end
                     default: next_st.result = RES_ERROR;
                  endcase
               end
            end
            default: ;
         endcase
      end

      // Reads
      if (rd) begin
         unique case (addr)
            ADDR_CTRL:      next_st.rdata = {31'h0, st.pers_req};
            ADDR_STATUS:    next_st.rdata = {24'h0, st.delaying, st.prov_blk, st.prov_ok,
                                             st.unblk_blk, st.pers_tmp, st.pers_blk,
                                             st.pers_ok, st.ping_on};
            ADDR_RESULT:    next_st.rdata = {29'h0, st.result};
            ADDR_IRQ_STAT:  next_st.rdata = {28'h0, st.irq_stat};
            ADDR_IRQ_MASK:  next_st.rdata = {28'h0, st.irq_mask};
            ADDR_PING_SIZE: next_st.rdata = {16'h0, st.ping_size};
            ADDR_PING_TMO:  next_st.rdata = {16'h0, st.ping_tmo};
            ADDR_UPTIME:    next_st.rdata = st.uptime;
            ADDR_PING_CNT:  next_st.rdata = {st.rx_cnt, st.tx_cnt};
            ADDR_CRED:      next_st.rdata = st.cred;
            ADDR_NET:       next_st.rdata = {31'h0, st.enc};
            default:        next_st.rdata = 32'h0000_0000;
         endcase
      end

      // Sticky status, set wins over clear
      next_st.irq_stat = next_st.irq_stat | ev;
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
   end

   // State register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.pers_key  <= PERS_KEY_RST;
         st.ping_size <= PING_DATA_RST;
         st.ping_tmo  <= PING_TMO_RST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state
   assign rdata       = st.rdata;
   assign encrypt_en  = st.enc;
   assign reg_req     = st.reg_req;
   assign dial_req    = st.dial_req;
   assign ping_active = st.ping_on;
   assign irq         = st.irq;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence s_prov_blk_entry;
      wr && addr == ADDR_CMD && wdata[3:0] == CMD_PROV_ENTRY && st.prov_blk
         && !st.delaying && wdata != MASTER_KEY && st.key != MASTER_KEY;
   endsequence
   property p_pers_gate;
      @(posedge mclk) disable iff (!resetn)
      (wr && addr == ADDR_CMD && wdata[3:0] == CMD_REGISTER && st.pers_req && !st.pers_ok)
         |=> !reg_req;
   endproperty
   a_pers_gate: assert property (p_pers_gate) else $error("register not gated"); // [RULE1]
   property p_pers_blk;
      @(posedge mclk) disable iff (!resetn)
      (st.pers_fail == PERS_FAIL_MAX) |-> st.pers_blk;
   endproperty
   a_pers_blk: assert property (p_pers_blk) else $error("personal key not blocked"); // [RULE2]
   property p_unblk_blk;
      @(posedge mclk) disable iff (!resetn)
      (st.unblk_fail == UNBLK_FAIL_MAX) |-> st.unblk_blk;
   endproperty
   a_unblk_blk: assert property (p_unblk_blk) else $error("unblock key not blocked"); // [RULE5]
   property p_prov_blk;
      @(posedge mclk) disable iff (!resetn)
      (st.prov_fail == PROV_FAIL_MAX) |-> st.prov_blk;
   endproperty
   a_prov_blk: assert property (p_prov_blk) else $error("provider key not blocked"); // [RULE9]
   property p_delay;
      @(posedge mclk) disable iff (!resetn)
      s_prov_blk_entry |=> st.delaying && st.result == RES_BUSY;
   endproperty
   a_delay: assert property (p_delay) else $error("blocked entry not delayed"); // [RULE10]
   property p_clear;
      @(posedge mclk) disable iff (!resetn)
      (wr && addr == ADDR_CMD && wdata[3:0] == CMD_CLEAR && st.prov_ok && !st.delaying)
         |=> !st.pers_blk && !st.unblk_blk && !st.prov_blk;
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed"); // [RULE6]
   property p_enc;
      @(posedge mclk) disable iff (!resetn)
      done_ev |=> encrypt_en == $past(net_enc_on);
   endproperty
   a_enc: assert property (p_enc) else $error("encryption not followed"); // [RULE17]
   property p_irq;
      @(posedge mclk) disable iff (!resetn)
      irq == |(st.irq_stat & st.irq_mask);
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch"); // [RULE14]
endmodule

// file: tb/security_key_lockout_tb_top.sv
// Self-checking bench for the key lockout core
`timescale 1ns/1ps
module security_key_lockout_tb_top;
   import skl_pkg::*;
   localparam int DLY = 20;
   localparam int SEC = 10;
   logic        mclk, resetn, wr, rd, echo_en, cfg_enc, reg_req, dial_req;
   logic        net_reg_done, net_enc_on, echo_reply, encrypt_en, ping_active, irq;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, net_cred, cfg_cred, v, rnd, e;
   int          bad_count, n_checks, n_reply, n_reg, n_dial, cyc, j;
   skl_core #(.DELAY_CYC(DLY), .SEC_CYCLES(SEC)) dut_u (.mclk(mclk), .resetn(resetn),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .net_reg_done(net_reg_done), .net_enc_on(net_enc_on), .net_cred(net_cred),
      .echo_reply(echo_reply), .encrypt_en(encrypt_en), .reg_req(reg_req),
      .dial_req(dial_req), .ping_active(ping_active), .irq(irq));
   skl_net_model net_u (.mclk(mclk), .reg_req(reg_req), .ping_active(ping_active),
      .echo_en(echo_en), .cfg_enc(cfg_enc), .cfg_cred(cfg_cred),
      .net_reg_done(net_reg_done), .net_enc_on(net_enc_on), .net_cred(net_cred),
      .echo_reply(echo_reply), .n_reply(n_reply));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Cycles since release and request pulse counts
   always @(posedge mclk) begin
      cyc <= resetn ? cyc + 1 : 0;
      n_reg <= n_reg + int'(reg_req === 1'b1);
      n_dial <= n_dial + int'(dial_req === 1'b1);
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Wrong key that never hits the real key or the master key
   function automatic logic [31:0] miss(input logic [31:0] r, input logic [31:0] k);
      return (r == k || r == MASTER_KEY) ? k ^ 32'h0000_0001 : r;
   endfunction
   function automatic logic [31:0] blk(input int n, input int lim);
      return {31'h0, n >= lim};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Key then command; result code left in v
   task automatic cmd(input logic [3:0] c, input logic [31:0] k);
      wr_reg(ADDR_KEY, k);
      wr_reg(ADDR_CMD, {28'h000_0000, c});
      rd_reg(ADDR_RESULT);
   endtask
   task automatic final_report;
      $display("Checks %0d, errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic poll(input logic [7:0] a, input logic [31:0] x, input int lim);
      for (int k = 0; k < lim; k++) begin
         rd_reg(a);
         if ((v & 32'h0000_00FF) === x) begin
            n_checks++;
            return;
         end
      end
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, v & 32'h0000_00FF, x);
      final_report();
   endtask
   // Run of wrong entries, status bit checked after each
   task automatic run_bad(input logic [3:0] c, input logic [31:0] k, input int n,
                          input int b, input int lim);
      for (int q = 0; q < n; q++) begin
         rnd = xs(rnd);
         cmd(c, miss(rnd, k));
         rd_reg(ADDR_STATUS);
         chk({31'h0, v[b]}, blk(q + 1, lim));
      end
   endtask
   initial begin
      {resetn, wr, rd, echo_en, cfg_enc, addr, wdata, cfg_cred} = '0;
      {bad_count, n_checks} = '0;
      rnd = 32'd76;
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      rd_reg(ADDR_CTRL);
      chk(v, 32'h0000_0000);
      rd_reg(ADDR_PING_SIZE);
      chk(v, {16'h0000, PING_DATA_RST});
      rd_reg(ADDR_PING_TMO);
      chk(v, {16'h0000, PING_TMO_RST});
      rd_reg(ADDR_CRED);
      chk(v, 32'h0000_0000);
      // Registrations without a personal key, both decisions
      for (j = 0; j < 2; j++) begin
         rnd = xs(rnd);
         cfg_enc <= (j == 0);
         cfg_cred <= rnd;
         cmd(CMD_REGISTER, 32'h0000_0000);
         chk(v & 32'h7, {29'h0, RES_OK});
         poll(ADDR_NET, {31'h0, j == 0}, 40);
         chk({31'h0, encrypt_en}, {31'h0, j == 0});
         rd_reg(ADDR_CRED);
         chk(v, rnd);
      end
      chk(n_reg, 2);
      // Interrupt masked, unmasked, cleared
      chk({31'h0, irq}, 32'h0);
      wr_reg(ADDR_IRQ_MASK, 32'h0000_000F);
      rd_reg(ADDR_IRQ_STAT);
      chk({31'h0, irq}, 32'h1);
      wr_reg(ADDR_IRQ_STAT, 32'h0000_000F);
      rd_reg(ADDR_IRQ_STAT);
      chk({31'h0, irq}, 32'h0);
      // Personal key required; provider gate cannot be switched off
      wr_reg(ADDR_CTRL, 32'hFFFF_FFFF);
      cmd(CMD_REGISTER, 32'h0000_0000);
      chk(v & 32'h7, {29'h0, RES_ERROR});
      cmd(CMD_DIAL, 32'h0000_0000);
      chk(v & 32'h7, {29'h0, RES_ERROR});
      cmd(CMD_CLEAR, 32'h0000_0000);
      chk(v & 32'h7, {29'h0, RES_ERROR});
      cmd(CMD_PROT_WRITE, 32'h0000_0000);
      chk(v & 32'h7, {29'h0, RES_ERROR});
      wr_reg(ADDR_PING_SIZE, 32'h0000_0063);
      rd_reg(ADDR_PING_SIZE);
      chk(v, {16'h0000, PING_DATA_RST});
      run_bad(CMD_PERS_ENTRY, PERS_KEY_RST, 2, 2, 3);
      cmd(CMD_PERS_ENTRY, PERS_KEY_RST);
      cmd(CMD_DIAL, 32'h0000_0000);
      chk(v & 32'h7, {29'h0, RES_OK});
      chk(n_dial + n_reg, 3);
      run_bad(CMD_PERS_ENTRY, PERS_KEY_RST, 3, 2, 3);
      rd_reg(ADDR_IRQ_STAT);
      chk({31'h0, v[IRQ_BLOCK]}, 32'h1);
      cmd(CMD_PERS_SET, 32'h0000_5A5A);
      chk(v & 32'h7, {29'h0, RES_BLOCKED});
      cmd(CMD_UNBLOCK, UNBLK_KEY_RST);
      rd_reg(ADDR_STATUS);
      chk({31'h0, v[3]}, 32'h1);
      cmd(CMD_PERS_SET, 32'h0000_5A5A);
      chk(v & 32'h7, {29'h0, RES_OK});
      run_bad(CMD_UNBLOCK, UNBLK_KEY_RST, 10, 4, 10);
      run_bad(CMD_PROV_ENTRY, PROV_KEY_RST, 3, 6, 3);
      // Blocked provider entry: busy, then blocked after the delay
      cmd(CMD_PROV_ENTRY, miss(xs(rnd), PROV_KEY_RST));
      chk(v & 32'h7, {29'h0, RES_BUSY});
      repeat (12) @(posedge mclk);
      rd_reg(ADDR_RESULT);
      chk(v & 32'h7, {29'h0, RES_BUSY});
      poll(ADDR_RESULT, {29'h0, RES_BLOCKED}, 10);
      cmd(CMD_PROV_ENTRY, MASTER_KEY);
      poll(ADDR_RESULT, {29'h0, RES_OK}, 30);
      cmd(CMD_CLEAR, 32'h0000_0000);
      rd_reg(ADDR_STATUS);
      chk(v & 32'h0000_0074, 32'h0000_0020);
      wr_reg(ADDR_PING_SIZE, 32'h0000_0064);
      rd_reg(ADDR_PING_SIZE);
      chk(v, 32'h0000_0064);
      cmd(CMD_PROT_WRITE, 32'h0000_0000);
      rd_reg(ADDR_CRED);
      chk(v, 32'h0000_0000);
      // Echo test with replies from the network
      echo_en <= 1'b1;
      cmd(CMD_PING_START, 32'h0000_0000);
      chk({31'h0, ping_active}, 32'h1);
      repeat (60) @(posedge mclk);
      echo_en <= 1'b0;
      repeat (20) @(posedge mclk);
      cmd(CMD_PING_STOP, 32'h0000_0000);
      chk({31'h0, ping_active}, 32'h0);
      rd_reg(ADDR_PING_CNT);
      chk({16'h0000, v[31:16]}, n_reply);
      chk({16'h0000, v[15:0]}, n_reply);
      rd_reg(ADDR_IRQ_STAT);
      chk({30'h0, v[3:2]}, 32'h3);
      rd_reg(ADDR_UPTIME);
      e = (cyc - 1) / SEC;
      chk(v, e);
      cmd(CMD_SOFT_RESET, 32'h0000_0000);
      rd_reg(ADDR_UPTIME);
      chk(v, 32'h0000_0000);
      final_report();
   end
endmodule

// file: tb/skl_net_model.sv
// Network side model: registration answers and echo replies
`timescale 1ns/1ps
module skl_net_model (
   // Clock
   input  wire logic        mclk,
   // From the block and the bench
   input  wire logic        reg_req,
   input  wire logic        ping_active,
   input  wire logic        echo_en,
   input  wire logic        cfg_enc,
   input  wire logic [31:0] cfg_cred,
   // Network lines
   output logic             net_reg_done,
   output logic             net_enc_on,
   output logic [31:0]      net_cred,
   output logic             echo_reply,
   output int               n_reply
);
   // Registration answer, decision held around the pulse only
   initial begin
      net_reg_done = 1'b0;
      net_enc_on   = 1'b0;
      net_cred     = 32'hA5A5_5A5A;
      forever begin
         @(posedge mclk);
         if (reg_req === 1'b1) begin
            repeat (4) @(posedge mclk);
            net_enc_on <= cfg_enc;
            net_cred   <= cfg_cred;
            repeat (2) @(posedge mclk);
            net_reg_done <= 1'b1;
            repeat (6) @(posedge mclk);
            net_reg_done <= 1'b0;
            repeat (4) @(posedge mclk);
            net_enc_on <= ~cfg_enc;
            net_cred   <= ~cfg_cred;
         end
      end
   end
   // Echo replies while a test runs and the bench allows
   initial begin
      echo_reply = 1'b0;
      n_reply    = 0;
      forever begin
         repeat (5) @(posedge mclk);
         if (ping_active === 1'b1 && echo_en) begin
            echo_reply <= 1'b1;
            n_reply    <= n_reply + 1;
            repeat (3) @(posedge mclk);
            echo_reply <= 1'b0;
         end
      end
   end
endmodule
